//--- rtl/gpc_pin_ctrl.sv
// Module: pin mode configuration registers and pin drive for pins 3 and 5 to 8
`timescale 1ns/1ps

// Notes on behaviour
// - Pin 3 in local output mode drives its output-value bit.
// - Pin 3 codes x00 give functional input, x10 give high impedance.
// - Pin 3 code 001 is local output, 011 is general input.
// - Code 101 drives remote value and keeps the last one on link loss.
// - Code 111 drives remote value, falls back to local bit on link loss.
// - Pins 5 to 8: 00 functional input, 10 high impedance.
// - Pins 5 to 8: 01 local output, 11 general input.
// - Pins 5 to 8 output bits: even pin bit 7, odd pin bit 3.
// - Even pin mode bits 5:4, odd pin mode bits 1:0, both pair registers.
// - All three configuration registers reset to zero.
module gpc_pin_ctrl
(
	input wire logic clock,
	input wire logic nrst,
	input wire gpc_pkg::gpc_reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic second_port_select,
	input wire logic link_up,
	input wire logic remote_pin_three,
	input wire logic [gpc_pkg::NUM_PINS-1:0] pin_in,
	output gpc_pkg::gpc_pin_out_t pin_out,
	output gpc_pkg::gpc_pin_sense_t pin_sense
);

	typedef struct packed {
		logic [7:0] pin3_config;
		logic [7:0] pin5_pin6_config;
		logic [7:0] pin7_pin8_config;
		logic remote_held;
		logic [7:0] rdata;
		logic rvalid;
		gpc_pkg::gpc_pin_out_t pins;
		gpc_pkg::gpc_pin_sense_t sense;
	} gpc_state_t;

	gpc_state_t state;
	gpc_state_t next_state;

	logic [2:0] mode [gpc_pkg::NUM_PINS];
	logic [gpc_pkg::NUM_PINS-1:0] local_value;
	logic [gpc_pkg::NUM_PINS-1:0] dec_drive;
	logic [gpc_pkg::NUM_PINS-1:0] dec_oe;
	logic [gpc_pkg::NUM_PINS-1:0] dec_func_in;
	logic [gpc_pkg::NUM_PINS-1:0] dec_gp_in;

	// Field extraction for every pin slot
	always_comb
	begin
		logic [2:0] pin3_mode;
		logic [7:0] pair;
		pin3_mode = state.pin3_config[gpc_pkg::POS_PIN3_MODE +: 3];
		pair = 8'h00;
		for (int i = 0; i < gpc_pkg::NUM_PINS; i++)
		begin
			mode[i] = {1'b0, gpc_pkg::MODE_LOW_FUNC_IN};
			local_value[i] = 1'b0;
		end
		// Unselected pin 3 slot rests in functional input
		if (second_port_select)
		begin
			mode[gpc_pkg::SLOT_SECOND_PIN3] = pin3_mode;
			local_value[gpc_pkg::SLOT_SECOND_PIN3] =
				state.pin3_config[gpc_pkg::POS_PIN3_VALUE];
		end
		else
		begin
			mode[gpc_pkg::SLOT_PIN3] = pin3_mode;
			local_value[gpc_pkg::SLOT_PIN3] = state.pin3_config[gpc_pkg::POS_PIN3_VALUE];
		end
		for (int p = 0; p < 2; p++)
		begin
			pair = (p == 0) ? state.pin5_pin6_config : state.pin7_pin8_config;
			mode[gpc_pkg::SLOT_PIN5 + 2 * p] =
				{1'b0, pair[gpc_pkg::POS_ODD_MODE +: 2]};
			mode[gpc_pkg::SLOT_PIN5 + 2 * p + 1] =
				{1'b0, pair[gpc_pkg::POS_EVEN_MODE +: 2]};
			local_value[gpc_pkg::SLOT_PIN5 + 2 * p] = pair[gpc_pkg::POS_ODD_VALUE];
			local_value[gpc_pkg::SLOT_PIN5 + 2 * p + 1] = pair[gpc_pkg::POS_EVEN_VALUE];
		end
	end

	genvar g;
	generate
		for (g = 0; g < gpc_pkg::NUM_PINS; g++)
		begin : g_pin
			gpc_pin_decode u_decode
			(
				.mode(mode[g]),
				.local_value(local_value[g]),
				// Only pin 3 slots carry a remote value
				.remote_value(g < gpc_pkg::SLOT_PIN5 ? remote_pin_three : 1'b0),
				.remote_held(g < gpc_pkg::SLOT_PIN5 ? state.remote_held : 1'b0),
				.link_up(link_up),
				.pin_in(pin_in[g]),
				.drive(dec_drive[g]),
				.oe(dec_oe[g]),
				.func_in(dec_func_in[g]),
				.gp_in(dec_gp_in[g])
			);
		end
	endgenerate

	always_comb
	begin
		next_state = state;
		if (reg_req.wr)
		begin
			unique case (reg_req.addr)
				gpc_pkg::ADDR_PIN3_CONFIG:
				begin
					next_state.pin3_config = reg_req.wdata & gpc_pkg::MASK_PIN3_CONFIG;
				end
				gpc_pkg::ADDR_PIN5_PIN6_CONFIG:
				begin
					next_state.pin5_pin6_config = reg_req.wdata & gpc_pkg::MASK_PAIR_CONFIG;
				end
				gpc_pkg::ADDR_PIN7_PIN8_CONFIG:
				begin
					next_state.pin7_pin8_config = reg_req.wdata & gpc_pkg::MASK_PAIR_CONFIG;
				end
				default:
				begin
					next_state.rvalid = state.rvalid;
				end
			endcase
		end
		next_state.rvalid = reg_req.rd;
		if (reg_req.rd)
		begin
			unique case (reg_req.addr)
				gpc_pkg::ADDR_PIN3_CONFIG: next_state.rdata = state.pin3_config;
				gpc_pkg::ADDR_PIN5_PIN6_CONFIG: next_state.rdata = state.pin5_pin6_config;
				gpc_pkg::ADDR_PIN7_PIN8_CONFIG: next_state.rdata = state.pin7_pin8_config;
				default: next_state.rdata = gpc_pkg::RDATA_UNMAPPED;
			endcase
		end
		// Held copy follows the remote value only while the link is good
		if (link_up)
		begin
			next_state.remote_held = remote_pin_three;
		end
		next_state.pins.drive = dec_drive;
		next_state.pins.oe = dec_oe;
		next_state.sense.func_in = dec_func_in;
		next_state.sense.gp_in = dec_gp_in;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			state <= '0;
			state.pin3_config <= gpc_pkg::RESET_CONFIG;
			state.pin5_pin6_config <= gpc_pkg::RESET_CONFIG;
			state.pin7_pin8_config <= gpc_pkg::RESET_CONFIG;
		end
		else
		begin
			state <= next_state;
		end
	end

	assign reg_rdata = state.rdata;
	assign reg_rvalid = state.rvalid;
	assign pin_out = state.pins;
	assign pin_sense = state.sense;

endmodule

//--- rtl/gpc_pkg.sv
// Package: register map, field layout and mode codes of the pin mode control
package gpc_pkg;

	localparam logic [7:0] ADDR_PIN3_CONFIG = 8'h0f;
	localparam logic [7:0] ADDR_PIN5_PIN6_CONFIG = 8'h10;
	localparam logic [7:0] ADDR_PIN7_PIN8_CONFIG = 8'h11;

	localparam logic [7:0] RESET_CONFIG = 8'h00;
	localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

	// Writable bits; everything else is reserved and reads zero
	localparam logic [7:0] MASK_PIN3_CONFIG = 8'h0f;
	localparam logic [7:0] MASK_PAIR_CONFIG = 8'hbb;

	localparam int POS_ODD_VALUE = 3;
	localparam int POS_EVEN_VALUE = 7;
	localparam int POS_ODD_MODE = 0;
	localparam int POS_EVEN_MODE = 4;
	localparam int POS_PIN3_MODE = 0;
	localparam int POS_PIN3_VALUE = 3;

	// Mode codes, 3-bit form; 2-bit pins use the same low bits with bit 2 clear
	localparam logic [1:0] MODE_LOW_FUNC_IN = 2'h0;
	localparam logic [1:0] MODE_LOW_TRISTATE = 2'h2;
	localparam logic [2:0] MODE_LOCAL_OUT = 3'h1;
	localparam logic [2:0] MODE_GP_IN = 3'h3;
	localparam logic [2:0] MODE_REMOTE_HOLD = 3'h5;
	localparam logic [2:0] MODE_REMOTE_DEFAULT = 3'h7;

	// Pin slots: 0 pin 3, 1 second port pin 3, 2..5 pins 5..8
	localparam int NUM_PINS = 6;
	localparam int SLOT_PIN3 = 0;
	localparam int SLOT_SECOND_PIN3 = 1;
	localparam int SLOT_PIN5 = 2;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} gpc_reg_req_t;

	typedef struct packed {
		logic [NUM_PINS-1:0] drive;
		logic [NUM_PINS-1:0] oe;
	} gpc_pin_out_t;

	typedef struct packed {
		logic [NUM_PINS-1:0] func_in;
		logic [NUM_PINS-1:0] gp_in;
	} gpc_pin_sense_t;

endpackage

//--- rtl/gpc_pin_decode.sv
// Module: decodes one pin's mode field into drive, enable and input routing
`timescale 1ns/1ps
module gpc_pin_decode
(
	input wire logic [2:0] mode,
	input wire logic local_value,
	input wire logic remote_value,
	input wire logic remote_held,
	input wire logic link_up,
	input wire logic pin_in,
	output logic drive,
	output logic oe,
	output logic func_in,
	output logic gp_in
);

	always_comb
	begin
		drive = 1'b0;
		oe = 1'b0;
		func_in = 1'b0;
		gp_in = 1'b0;
		if (mode[1:0] == gpc_pkg::MODE_LOW_FUNC_IN)
		begin
			func_in = pin_in;
		end
		else if (mode[1:0] == gpc_pkg::MODE_LOW_TRISTATE)
		begin
			oe = 1'b0;
		end
		else if (mode == gpc_pkg::MODE_LOCAL_OUT)
		begin
			oe = 1'b1;
			drive = local_value;
		end
		else if (mode == gpc_pkg::MODE_GP_IN)
		begin
			gp_in = pin_in;
		end
		else if (mode == gpc_pkg::MODE_REMOTE_HOLD)
		begin
			oe = 1'b1;
			// Held copy already tracks the live value while the link is up
			drive = link_up ? remote_value : remote_held;
		end
		else
		begin
			oe = 1'b1;
			drive = link_up ? remote_value : local_value;
		end
	end

endmodule

//--- verification/gpc_far_side.sv
// Pin-side model: outside circuits resolved against the block's own drive
`timescale 1ns/1ps
module gpc_far_side
(
	input wire gpc_pkg::gpc_pin_out_t pin_out,
	input wire logic [5:0] ext_level,
	output logic [5:0] pin_in
);
	// A driven pin reads back its own level, else the outside level
	assign pin_in = (pin_out.oe & pin_out.drive) | (~pin_out.oe & ext_level);
endmodule

//--- verification/gpc_pin_ctrl_properties.sv
// Checker: port-level properties of the pin mode control
`timescale 1ns/1ps
module gpc_pin_props
(
	input wire logic clock,
	input wire logic nrst,
	input wire gpc_pkg::gpc_reg_req_t reg_req,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic second_port_select,
	input wire logic link_up,
	input wire logic remote_pin_three,
	input wire logic [gpc_pkg::NUM_PINS-1:0] pin_in,
	input wire gpc_pkg::gpc_pin_out_t pin_out,
	input wire gpc_pkg::gpc_pin_sense_t pin_sense
);
	logic [7:0] c3, c56, c78, rd_exp;
	logic [3:0] lo, lv, gi, fi;
	logic [2:0] m, m1;
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// Shadow registers with reserved bits masked
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			{c3, c56, c78} <= 24'h00_0000;
		else if (reg_req.wr)
			case (reg_req.addr)
				8'h0f: c3 <= reg_req.wdata & 8'h0f;
				8'h10: c56 <= reg_req.wdata & 8'hbb;
				8'h11: c78 <= reg_req.wdata & 8'hbb;
				default: ;
			endcase
	end
	// Unselected slot acts as functional input
	assign m = second_port_select ? 3'h0 : c3[2:0];
	assign m1 = second_port_select ? c3[2:0] : 3'h0;
	assign lo = {c78[5:4] == 2'h1, c78[1:0] == 2'h1, c56[5:4] == 2'h1, c56[1:0] == 2'h1};
	assign gi = {&c78[5:4], &c78[1:0], &c56[5:4], &c56[1:0]};
	assign lv = {c78[7], c78[3], c56[7], c56[3]};
	assign fi = {c78[5:4] == 2'h0, c78[1:0] == 2'h0, c56[5:4] == 2'h0, c56[1:0] == 2'h0};
	assign rd_exp = reg_req.addr == 8'h0f ? c3 : reg_req.addr == 8'h10 ? c56
		: reg_req.addr == 8'h11 ? c78 : 8'h00;
	read_back_a: assert property (reg_req.rd |=> reg_rvalid && reg_rdata == $past(rd_exp))
		else $error("bad read");
	local_out_a: assert property (m == 3'h1 |=> pin_out.oe[0] && pin_out.drive[0] == $past(c3[3]))
		else $error("bad local output");
	func_in_a: assert property (m[1:0] == 2'h0
		|=> !pin_out.oe[0] && pin_sense.func_in[0] == $past(pin_in[0])) else $error("bad func input");
	gp_in_a: assert property (m == 3'h3
		|=> !pin_out.oe[0] && pin_sense.gp_in[0] == $past(pin_in[0])) else $error("bad gp input");
	remote_drive_a: assert property (m[2] && m[0] && link_up
		|=> pin_out.oe[0] && pin_out.drive[0] == $past(remote_pin_three)) else $error("bad remote");
	link_fallback_a: assert property (m == 3'h7 && !link_up
		|=> pin_out.oe[0] && pin_out.drive[0] == $past(c3[3])) else $error("bad fallback");
	link_hold_a: assert property ((m == 3'h5 && !link_up) [*2]
		|=> pin_out.oe[0] && $stable(pin_out.drive[0])) else $error("bad hold");
	second_slot_a: assert property (1'b1 |=> pin_out.oe[1] == $past(m1[0] && m1 != 3'h3))
		else $error("bad second port");
	pair_out_a: assert property (1'b1 |=> pin_out.oe[5:2] == $past(lo)
		&& (pin_out.drive[5:2] & pin_out.oe[5:2]) == $past(lv & lo)) else $error("bad pair out");
	pair_in_a: assert property (1'b1 |=> pin_sense.gp_in[5:2] == $past(gi & pin_in[5:2]))
		else $error("bad pair input");
	pair_func_a: assert property (1'b1 |=> pin_sense.func_in[5:2] == $past(fi & pin_in[5:2]))
		else $error("bad pair func input");
	second_sense_a: assert property (1'b1
		|=> pin_sense.gp_in[1] == $past(m1 == 3'h3 && pin_in[1])
		&& pin_sense.func_in[1] == $past(m1[1:0] == 2'h0 && pin_in[1]))
		else $error("bad second port input");
endmodule
bind gpc_pin_ctrl gpc_pin_props i_gpc_pin_props
(
	.clock(clock),
	.nrst(nrst),
	.reg_req(reg_req),
	.reg_rdata(reg_rdata),
	.reg_rvalid(reg_rvalid),
	.second_port_select(second_port_select),
	.link_up(link_up),
	.remote_pin_three(remote_pin_three),
	.pin_in(pin_in),
	.pin_out(pin_out),
	.pin_sense(pin_sense)
);

//--- verification/gpc_pin_ctrl_tb.sv
// Testbench: register and pin checks of the pin mode control
`timescale 1ns/1ps
`define CHK(n, e, g) \
	begin check_count++; if ((g) !== (e)) begin error_cnt++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
module gpc_pin_ctrl_tb;
	logic clock = 0;
	logic nrst = 0;
	gpc_pkg::gpc_reg_req_t reg_req = '0;
	logic [7:0] reg_rdata;
	logic reg_rvalid;
	logic second_port_select = 0;
	logic link_up = 1;
	logic remote_pin_three = 0;
	logic [5:0] pin_in;
	logic [5:0] ext_level = 6'h3f;
	gpc_pkg::gpc_pin_out_t pin_out;
	gpc_pkg::gpc_pin_sense_t pin_sense;
	int error_cnt = 0;
	int check_count = 0;
	always #12.5 clock = ~clock;
	gpc_pin_ctrl i_gpc_pin_ctrl
	(
		.clock(clock),
		.nrst(nrst),
		.reg_req(reg_req),
		.reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid),
		.second_port_select(second_port_select),
		.link_up(link_up),
		.remote_pin_three(remote_pin_three),
		.pin_in(pin_in),
		.pin_out(pin_out),
		.pin_sense(pin_sense)
	);
	gpc_far_side i_gpc_far_side
	(
		.pin_out(pin_out),
		.ext_level(ext_level),
		.pin_in(pin_in)
	);
	// Returns once the written config has reached the pins
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_req = '{1'b1, 1'b0, a, d};
		@(negedge clock);
		reg_req.wr = 1'b0;
		@(negedge clock);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clock);
		reg_req = '{1'b0, 1'b1, a, 8'h00};
		@(negedge clock);
		reg_req.rd = 1'b0;
		`CHK("rvalid", 1'b1, reg_rvalid)
		`CHK("rdata", e, reg_rdata)
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(negedge clock);
		nrst = 1;
		for (int i = 15; i < 19; i++)
			rd(8'(i), 8'h00);
		wr(8'h0f, 8'hff);
		wr(8'h10, 8'hff);
		wr(8'h11, 8'hff);
		rd(8'h0f, 8'h0f);
		rd(8'h10, 8'hbb);
		rd(8'h11, 8'hbb);
		$display("test registers done");
		// Local bit high, remote low, so only local output mode drives high
		for (int m = 0; m < 8; m++)
		begin
			wr(8'h0f, 8'(8 + m));
			// Sense sees the pin one edge after the old drive lets go
			@(negedge clock);
			`CHK("oe3", m == 1 || m > 4 && m[0], pin_out.oe[0])
			`CHK("drive3", m == 1, pin_out.drive[0] & pin_out.oe[0])
			`CHK("gp3", m == 3, pin_sense.gp_in[0])
			`CHK("func3", m % 4 == 0, pin_sense.func_in[0])
		end
		$display("test pin three modes done");
		remote_pin_three = 1;
		wr(8'h0f, 8'h05);
		`CHK("remote", 1'b1, pin_out.drive[0])
		link_up = 0;
		remote_pin_three = 0;
		repeat (2) @(negedge clock);
		`CHK("hold", 1'b1, pin_out.drive[0])
		remote_pin_three = 1;
		wr(8'h0f, 8'h07);
		`CHK("fallback", 1'b0, pin_out.drive[0])
		link_up = 1;
		@(negedge clock);
		`CHK("relink", 1'b1, pin_out.drive[0])
		$display("test link loss done");
		wr(8'h10, 8'h91);
		wr(8'h11, 8'h3a);
		`CHK("oe58", 4'h3, pin_out.oe[5:2])
		`CHK("drive56", 2'h2, pin_out.drive[3:2])
		`CHK("gp58", 4'h8, pin_sense.gp_in[5:2])
		$display("test pins five to eight done");
		second_port_select = 1;
		wr(8'h0f, 8'h09);
		`CHK("oe second", 2'h2, pin_out.oe[1:0])
		`CHK("drive second", 1'b1, pin_out.drive[1])
		$display("test second port done");
		nrst = 0;
		repeat (2) @(negedge clock);
		`CHK("oe reset", 6'h00, pin_out.oe)
		`CHK("rvalid reset", 1'b0, reg_rvalid)
		nrst = 1;
		rd(8'h0f, 8'h00);
		rd(8'h10, 8'h00);
		rd(8'h11, 8'h00);
		$display("test mid-run reset done");
		complete_run;
	end
endmodule
